/* design/mhp_pkg.sv */
// constants shared by the host port device end and the host end
`default_nettype none
package mhp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	// address phase, strobe width and hold after strobe, host side
	localparam int unsigned T_ADDR_NS = 16;
	localparam int unsigned T_STROBE_NS = 32;
	localparam int unsigned T_HOLD_NS = 8;
	localparam int unsigned ADDR_CYC = (T_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUS_W = 8;
	localparam int unsigned CHAN_BIT = 6;
	localparam logic [2:0] MCR_OFF = 3'h4;
	localparam logic [2:0] MSR_OFF = 3'h6;
	localparam logic [2:0] SCR_OFF = 3'h7;
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [7:0] SCR_RST = 8'h00;
	localparam int unsigned MCR_DTR = 0;
	localparam int unsigned MCR_RTS = 1;
	localparam int unsigned MCR_IRQEN = 3;
	localparam int unsigned MSR_DCTS = 0;
	localparam int unsigned MSR_DDSR = 1;
	localparam int unsigned MSR_DDCD = 3;
	localparam int unsigned MSR_CTS = 4;
	localparam int unsigned MSR_DSR = 5;
	localparam int unsigned MSR_DCD = 7;
	// host controller registers
	localparam logic [3:0] H_ADDR_OFF = 4'h0;
	localparam logic [3:0] H_WDATA_OFF = 4'h1;
	localparam logic [3:0] H_CTRL_OFF = 4'h2;
	localparam logic [3:0] H_STAT_OFF = 4'h3;
	localparam logic [3:0] H_RDATA_OFF = 4'h4;
	localparam int unsigned H_CTRL_RD = 0;
	localparam int unsigned H_CTRL_WR = 1;
	localparam int unsigned H_STAT_BUSY = 0;
	localparam int unsigned H_STAT_IRQA = 1;
	localparam int unsigned H_STAT_IRQB = 2;
	localparam int unsigned H_STAT_DONE = 3;
	typedef enum logic [4:0] {
		HST_IDLE = 5'h01,
		HST_ADDR = 5'h02,
		HST_GAP = 5'h04,
		HST_STRB = 5'h08,
		HST_HOLD = 5'h10
	} mhp_hst_t;
endpackage : mhp_pkg
`default_nettype wire

/* design/mhp_if.sv */
// shared bus and strobes between host and device, with wire resolution
`default_nettype none
interface mhp_if;
	logic cs_n;
	logic addr_latch_strobe_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic [7:0] host_ad_out;
	logic host_ad_oe;
	logic [7:0] dev_ad_out;
	logic dev_ad_oe;
	logic [7:0] ad;
	logic irq_out_a;
	logic irq_oe_a;
	logic irq_out_b;
	logic irq_oe_b;
	logic irq_a;
	logic irq_b;
	// undriven bus floats high through pull-ups, undriven irq pulled low
	assign ad = host_ad_oe ? host_ad_out : (dev_ad_oe ? dev_ad_out : 8'hFF);
	assign irq_a = irq_oe_a & irq_out_a;
	assign irq_b = irq_oe_b & irq_out_b;
	modport dev_mp (
		input cs_n, addr_latch_strobe_n, read_strobe_n, write_strobe_n, ad,
		output dev_ad_out, dev_ad_oe, irq_out_a, irq_oe_a, irq_out_b, irq_oe_b
	);
	modport host_mp (
		output cs_n, addr_latch_strobe_n, read_strobe_n, write_strobe_n, host_ad_out, host_ad_oe,
		input ad, irq_a, irq_b
	);
endinterface : mhp_if
`default_nettype wire

/* design/mhp_dev.sv */
// device end: address latch, strobed register access, modem pins
//
// Implementation choices: the plain strobed port and the register offsets.
`default_nettype none
module mhp_dev (
	input wire logic clk,
	input wire logic sys_rst,
	mhp_if.dev_mp bus,
	input wire logic carrier_detect_n_a,
	input wire logic carrier_detect_n_b,
	input wire logic clear_to_send_in_a,
	input wire logic clear_to_send_in_b,
	input wire logic set_ready_in_a,
	input wire logic set_ready_in_b,
	output logic terminal_ready_out_a,
	output logic terminal_ready_out_b,
	output logic request_to_send_out_a,
	output logic request_to_send_out_b
);
	logic [7:0] addr_q;
	logic rd_prev_q;
	logic wr_prev_q;
	logic wr_pend_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic oe_q;
	logic [7:0] mcr_q [2];
	logic [7:0] scr_q [2];
	// per channel: {carrier, set ready, clear to send} asserted levels
	logic [2:0] lvl_q [2];
	logic [2:0] dlt_q [2];
	logic [2:0] cur [2];
	logic [7:0] modem_status_reg [2];
	logic data_phase;
	logic rd_fall;
	logic wr_fall;
	logic wr_rise;
	logic chan;
	logic [2:0] sel;
	logic [1:0] hit_mcr;
	logic [1:0] hit_scr;
	logic [1:0] hit_msr;

	assign data_phase = !bus.cs_n && bus.addr_latch_strobe_n;
	assign rd_fall = data_phase && rd_prev_q && !bus.read_strobe_n;
	assign wr_fall = data_phase && wr_prev_q && !bus.write_strobe_n;
	assign wr_rise = !bus.cs_n && wr_pend_q && !wr_prev_q && bus.write_strobe_n;
	assign chan = addr_q[mhp_pkg::CHAN_BIT];
	assign sel = addr_q[2:0];

	// active-low modem inputs turned into asserted levels
	assign cur[0] = {~carrier_detect_n_a, ~set_ready_in_a, ~clear_to_send_in_a};
	assign cur[1] = {~carrier_detect_n_b, ~set_ready_in_b, ~clear_to_send_in_b};

	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			modem_status_reg[ch] = 8'h00;
			modem_status_reg[ch][mhp_pkg::MSR_DCTS] = dlt_q[ch][0];
			modem_status_reg[ch][mhp_pkg::MSR_DDSR] = dlt_q[ch][1];
			modem_status_reg[ch][mhp_pkg::MSR_DDCD] = dlt_q[ch][2];
			modem_status_reg[ch][mhp_pkg::MSR_CTS] = lvl_q[ch][0];
			modem_status_reg[ch][mhp_pkg::MSR_DSR] = lvl_q[ch][1];
			modem_status_reg[ch][mhp_pkg::MSR_DCD] = lvl_q[ch][2];
		end
	end

	// address latch, held until the next address phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q <= 8'h00;
		end else if (!bus.cs_n && !bus.addr_latch_strobe_n) begin
			addr_q <= bus.ad;
		end
	end

	// strobe history for edge detection
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			rd_prev_q <= bus.read_strobe_n;
			wr_prev_q <= bus.write_strobe_n;
		end
	end

	// write cycle armed by the falling edge, dropped if chip select leaves
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
		end else if (bus.cs_n || wr_rise) begin
			wr_pend_q <= 1'b0;
		end else if (wr_fall) begin
			wr_pend_q <= 1'b1;
		end
	end

	// bus byte tracked while write strobe low; stored value is the last one seen
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdata_q <= 8'h00;
		end else if (data_phase && !bus.write_strobe_n) begin
			wdata_q <= bus.ad;
		end
	end

	// per-channel write and status-read decode from the latched address
	assign hit_mcr[0] = wr_rise && !chan && sel == mhp_pkg::MCR_OFF;
	assign hit_mcr[1] = wr_rise && chan && sel == mhp_pkg::MCR_OFF;
	assign hit_scr[0] = wr_rise && !chan && sel == mhp_pkg::SCR_OFF;
	assign hit_scr[1] = wr_rise && chan && sel == mhp_pkg::SCR_OFF;
	assign hit_msr[0] = rd_fall && !chan && sel == mhp_pkg::MSR_OFF;
	assign hit_msr[1] = rd_fall && chan && sel == mhp_pkg::MSR_OFF;

	// modem control registers; reset leaves both modem outputs high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int ch = 0; ch < 2; ch++) begin
				mcr_q[ch] <= mhp_pkg::MCR_RST;
			end
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (hit_mcr[ch]) begin
					mcr_q[ch] <= wdata_q;
				end
			end
		end
	end

	// scratch registers, spare storage for software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int ch = 0; ch < 2; ch++) begin
				scr_q[ch] <= mhp_pkg::SCR_RST;
			end
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (hit_scr[ch]) begin
					scr_q[ch] <= wdata_q;
				end
			end
		end
	end

	// asserted input levels, one cycle behind the pins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int ch = 0; ch < 2; ch++) begin
				lvl_q[ch] <= 3'h0;
			end
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				lvl_q[ch] <= cur[ch];
			end
		end
	end

	// sticky change flags; a change beats a clearing read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int ch = 0; ch < 2; ch++) begin
				dlt_q[ch] <= 3'h0;
			end
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (hit_msr[ch]) begin
					dlt_q[ch] <= lvl_q[ch] ^ cur[ch];
				end else begin
					dlt_q[ch] <= dlt_q[ch] | (lvl_q[ch] ^ cur[ch]);
				end
			end
		end
	end

	// read byte captured at the read strobe falling edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (rd_fall) begin
			unique case (sel)
				mhp_pkg::MCR_OFF: rdata_q <= mcr_q[chan];
				mhp_pkg::MSR_OFF: rdata_q <= modem_status_reg[chan];
				mhp_pkg::SCR_OFF: rdata_q <= scr_q[chan];
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// bus driven one cycle behind the read strobe being low in the data phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= data_phase && !bus.read_strobe_n;
		end
	end

	assign bus.dev_ad_out = rdata_q;
	assign bus.dev_ad_oe = oe_q;
	assign bus.irq_out_a = |dlt_q[0];
	assign bus.irq_out_b = |dlt_q[1];
	assign bus.irq_oe_a = mcr_q[0][mhp_pkg::MCR_IRQEN];
	assign bus.irq_oe_b = mcr_q[1][mhp_pkg::MCR_IRQEN];
	assign terminal_ready_out_a = ~mcr_q[0][mhp_pkg::MCR_DTR];
	assign terminal_ready_out_b = ~mcr_q[1][mhp_pkg::MCR_DTR];
	assign request_to_send_out_a = ~mcr_q[0][mhp_pkg::MCR_RTS];
	assign request_to_send_out_b = ~mcr_q[1][mhp_pkg::MCR_RTS];
endmodule : mhp_dev
`default_nettype wire

/* design/mhp_host.sv */
// host end: runs one multiplexed address/data transfer per software order
`default_nettype none
module mhp_host #(
	parameter int unsigned ADDR_CYC = mhp_pkg::ADDR_CYC,
	parameter int unsigned STROBE_CYC = mhp_pkg::STROBE_CYC,
	parameter int unsigned HOLD_CYC = mhp_pkg::HOLD_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	mhp_if.host_mp bus,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	if (ADDR_CYC < 1 || ADDR_CYC > 15 || STROBE_CYC < 2 || STROBE_CYC > 15 || HOLD_CYC < 1 || HOLD_CYC > 15) begin
		$error("mhp_host: phase lengths out of range");
	end

	mhp_pkg::mhp_hst_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdres_q;
	logic is_wr_q;
	logic done_q;
	logic start;
	logic last;
	logic [7:0] stat;

	assign start = reg_wr && reg_addr == mhp_pkg::H_CTRL_OFF && state_q == mhp_pkg::HST_IDLE
		&& (reg_wdata[mhp_pkg::H_CTRL_RD] || reg_wdata[mhp_pkg::H_CTRL_WR]);
	always_comb begin
		last = 1'b0;
		unique case (state_q)
			mhp_pkg::HST_ADDR: last = cnt_q == 4'(ADDR_CYC - 1);
			mhp_pkg::HST_STRB: last = cnt_q == 4'(STROBE_CYC - 1);
			mhp_pkg::HST_HOLD: last = cnt_q == 4'(HOLD_CYC - 1);
			mhp_pkg::HST_GAP: last = 1'b1;
			mhp_pkg::HST_IDLE: last = 1'b0;
		endcase
	end

	// transfer sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= mhp_pkg::HST_IDLE;
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
			unique case (state_q)
				mhp_pkg::HST_IDLE: begin
					cnt_q <= 4'h0;
					if (start) begin
						state_q <= mhp_pkg::HST_ADDR;
					end
				end
				mhp_pkg::HST_ADDR: if (last) state_q <= mhp_pkg::HST_GAP;
				mhp_pkg::HST_GAP: state_q <= mhp_pkg::HST_STRB;
				mhp_pkg::HST_STRB: if (last) state_q <= mhp_pkg::HST_HOLD;
				mhp_pkg::HST_HOLD: if (last) state_q <= mhp_pkg::HST_IDLE;
			endcase
		end
	end

	// software registers; orders while busy are ignored
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			is_wr_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == mhp_pkg::H_ADDR_OFF) addr_q <= reg_wdata;
			if (reg_addr == mhp_pkg::H_WDATA_OFF) wdata_q <= reg_wdata;
			if (start) is_wr_q <= reg_wdata[mhp_pkg::H_CTRL_WR];
		end
	end

	// read byte taken in the last strobe cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdres_q <= 8'h00;
		end else if (state_q == mhp_pkg::HST_STRB && last && !is_wr_q) begin
			rdres_q <= bus.ad;
		end
	end

	// done flag: completion beats a clearing status read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_q <= 1'b0;
		end else if (state_q == mhp_pkg::HST_HOLD && last) begin
			done_q <= 1'b1;
		end else if (reg_rd && reg_addr == mhp_pkg::H_STAT_OFF) begin
			done_q <= 1'b0;
		end
	end

	always_comb begin
		stat = 8'h00;
		stat[mhp_pkg::H_STAT_BUSY] = state_q != mhp_pkg::HST_IDLE;
		stat[mhp_pkg::H_STAT_IRQA] = bus.irq_a;
		stat[mhp_pkg::H_STAT_IRQB] = bus.irq_b;
		stat[mhp_pkg::H_STAT_DONE] = done_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				mhp_pkg::H_ADDR_OFF: reg_rdata <= addr_q;
				mhp_pkg::H_WDATA_OFF: reg_rdata <= wdata_q;
				mhp_pkg::H_STAT_OFF: reg_rdata <= stat;
				mhp_pkg::H_RDATA_OFF: reg_rdata <= rdres_q;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign bus.cs_n = state_q == mhp_pkg::HST_IDLE;
	assign bus.addr_latch_strobe_n = state_q != mhp_pkg::HST_ADDR;
	assign bus.read_strobe_n = !(state_q == mhp_pkg::HST_STRB && !is_wr_q);
	assign bus.write_strobe_n = !(state_q == mhp_pkg::HST_STRB && is_wr_q);
	assign bus.host_ad_out = state_q == mhp_pkg::HST_ADDR ? addr_q : wdata_q;
	assign bus.host_ad_oe = state_q == mhp_pkg::HST_ADDR || (is_wr_q && state_q != mhp_pkg::HST_IDLE);
endmodule : mhp_host
`default_nettype wire

/* verification/mhp_checker.sv */
// wire-level assertions for the host port link
`default_nettype none
module mhp_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic addr_latch_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic host_ad_oe,
	input wire logic dev_ad_oe,
	input wire logic irq_oe_a,
	input wire logic irq_oe_b
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_addr;
		(!addr_latch_strobe_n && host_ad_oe && !cs_n) [*2];
	endsequence
	sequence s_gap;
		addr_latch_strobe_n && read_strobe_n && write_strobe_n && !cs_n;
	endsequence
	a_addr_then_gap: assert property ($fell(cs_n) |-> s_addr ##1 s_gap)
		else $error("address phase malformed");
	a_read_drive: assert property ($fell(read_strobe_n) && !cs_n |=> dev_ad_oe [*4])
		else $error("device not driving during read");
	a_read_release: assert property ($rose(read_strobe_n) && !cs_n |-> dev_ad_oe ##1 !dev_ad_oe)
		else $error("device bus release wrong");
	a_dev_quiet: assert property (cs_n && $past(cs_n) |-> !dev_ad_oe)
		else $error("device drives while unselected");
	a_no_contention: assert property (!(host_ad_oe && dev_ad_oe))
		else $error("both ends drive the bus");
	a_phase_order: assert property (!addr_latch_strobe_n |-> read_strobe_n && write_strobe_n)
		else $error("strobe during address phase");
	a_write_frame: assert property ($fell(write_strobe_n) |-> (host_ad_oe && !cs_n) [*4] ##1 write_strobe_n)
		else $error("write phase malformed");
	a_irq_en_time: assert property ($changed({irq_oe_a, irq_oe_b}) |-> $past(write_strobe_n) && !$past(write_strobe_n, 2))
		else $error("irq enable changed outside a write");
endmodule : mhp_checker
`default_nettype wire

/* verification/mhp_tb_top.sv */
// bench: host end drives device end across the shared bus
`default_nettype none
module muxed_host_port_modem_pins_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [1:0] cd_n, cts_n, dsr_n, dtr_n, rts_n;
	int errors, cmp_count;
	mhp_if bus ();
	mhp_dev mhp_dev_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.carrier_detect_n_a(cd_n[0]), .carrier_detect_n_b(cd_n[1]),
		.clear_to_send_in_a(cts_n[0]), .clear_to_send_in_b(cts_n[1]),
		.set_ready_in_a(dsr_n[0]), .set_ready_in_b(dsr_n[1]),
		.terminal_ready_out_a(dtr_n[0]), .terminal_ready_out_b(dtr_n[1]),
		.request_to_send_out_a(rts_n[0]), .request_to_send_out_b(rts_n[1]));
	mhp_host mhp_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	mhp_checker mhp_checker_inst (.clk(clk), .sys_rst(sys_rst), .cs_n(bus.cs_n),
		.addr_latch_strobe_n(bus.addr_latch_strobe_n), .read_strobe_n(bus.read_strobe_n),
		.write_strobe_n(bus.write_strobe_n), .host_ad_oe(bus.host_ad_oe), .dev_ad_oe(bus.dev_ad_oe),
		.irq_oe_a(bus.irq_oe_a), .irq_oe_b(bus.irq_oe_b));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] v, input logic [7:0] e, input string n);
		cmp_count++;
		if (v !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	function automatic logic [7:0] adr(input int ch, input logic [2:0] off);
		return {1'b0, ch[0], 3'h0, off};
	endfunction : adr
	// c is 8'h01 for a read, 8'h02 for a write; result lands in d
	task automatic xfer(input logic [7:0] a, input logic [7:0] v, input logic [7:0] c);
		int i;
		wr(mhp_pkg::H_ADDR_OFF, a);
		wr(mhp_pkg::H_WDATA_OFF, v);
		wr(mhp_pkg::H_CTRL_OFF, c);
		for (i = 0; i < 40; i++) begin
			rd(mhp_pkg::H_STAT_OFF);
			if (d[mhp_pkg::H_STAT_BUSY] === 1'b0) break;
		end
		if (i == 40) begin
			errors++;
			final_report();
		end
		rd(mhp_pkg::H_RDATA_OFF);
	endtask : xfer
	task automatic t_reset();
		chk({6'h00, dtr_n}, 8'h03, "terminal ready reset");
		chk({6'h00, rts_n}, 8'h03, "request to send reset");
		chk({6'h00, bus.irq_oe_b, bus.irq_oe_a}, 8'h00, "irq enable reset");
		$display("test reset done");
	endtask : t_reset
	task automatic t_ctrl();
		for (int ch = 0; ch < 2; ch++) begin
			xfer(adr(ch, mhp_pkg::MCR_OFF), 8'h0B, 8'h02);
			chk({6'h00, dtr_n}, ch ? 8'h01 : 8'h02, "terminal ready on");
			chk({6'h00, rts_n}, ch ? 8'h01 : 8'h02, "request to send on");
			chk({6'h00, bus.irq_oe_b, bus.irq_oe_a}, ch ? 8'h02 : 8'h01, "irq enable");
			xfer(adr(ch, mhp_pkg::MCR_OFF), 8'h00, 8'h01);
			chk(d, 8'h0B, "control readback");
			xfer(adr(ch, mhp_pkg::MCR_OFF), 8'h00, 8'h02);
			chk({6'h00, dtr_n}, 8'h03, "terminal ready off");
		end
		$display("test control done");
	endtask : t_ctrl
	task automatic t_bits();
		for (int i = 0; i < 8; i++) begin
			xfer(adr(0, mhp_pkg::SCR_OFF), 8'h01 << i, 8'h02);
			xfer(adr(1, mhp_pkg::SCR_OFF), 8'h80 >> i, 8'h02);
			xfer(adr(0, mhp_pkg::SCR_OFF), 8'h00, 8'h01);
			chk(d, 8'h01 << i, "scratch a");
			xfer(adr(1, mhp_pkg::SCR_OFF), 8'h00, 8'h01);
			chk(d, 8'h80 >> i, "scratch b");
		end
		$display("test bit order done");
	endtask : t_bits
	task automatic t_status();
		logic [2:0] q;
		for (int p = 0; p < 8; p++) begin
			q = 3'(p);
			@(posedge clk);
			cd_n <= {~q[0], q[0]};
			cts_n <= {~q[1], q[1]};
			dsr_n <= {~q[2], q[2]};
			xfer(adr(0, mhp_pkg::MSR_OFF), 8'h00, 8'h01);
			chk(d & 8'hB0, {~q[0], 1'b0, ~q[2], ~q[1], 4'h0}, "status a");
			xfer(adr(1, mhp_pkg::MSR_OFF), 8'h00, 8'h01);
			chk(d & 8'hB0, {q[0], 1'b0, q[2], q[1], 4'h0}, "status b");
		end
		$display("test status done");
	endtask : t_status
	task automatic t_irq();
		xfer(adr(0, mhp_pkg::MCR_OFF), 8'h08, 8'h02);
		xfer(adr(0, mhp_pkg::MSR_OFF), 8'h00, 8'h01);
		chk({7'h00, bus.irq_a}, 8'h00, "irq quiet");
		@(posedge clk);
		cts_n[0] <= ~cts_n[0];
		for (int i = 0; i < 8 && bus.irq_a !== 1'b1; i++) @(posedge clk);
		chk({7'h00, bus.irq_a}, 8'h01, "irq on change");
		rd(mhp_pkg::H_STAT_OFF);
		chk(d & 8'h06, 8'h02, "irq a status");
		xfer(adr(0, mhp_pkg::MCR_OFF), 8'h00, 8'h02);
		chk({7'h00, bus.irq_a}, 8'h00, "irq floated");
		xfer(adr(1, mhp_pkg::MCR_OFF), 8'h08, 8'h02);
		xfer(adr(1, mhp_pkg::MSR_OFF), 8'h00, 8'h01);
		chk({7'h00, bus.irq_b}, 8'h00, "irq b quiet");
		@(posedge clk);
		dsr_n[1] <= ~dsr_n[1];
		for (int i = 0; i < 8 && bus.irq_b !== 1'b1; i++) @(posedge clk);
		rd(mhp_pkg::H_STAT_OFF);
		chk(d & 8'h06, 8'h04, "irq b status");
		xfer(adr(1, mhp_pkg::MCR_OFF), 8'h00, 8'h02);
		chk({7'h00, bus.irq_b}, 8'h00, "irq b floated");
		$display("test irq done");
	endtask : t_irq
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		cd_n = 2'h3;
		cts_n = 2'h3;
		dsr_n = 2'h3;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_ctrl();
		t_bits();
		t_status();
		t_irq();
		final_report();
	end
endmodule : muxed_host_port_modem_pins_tb_top
`default_nettype wire
